// ===== rtl/lane_cfg_pkg.sv
package lane_cfg_pkg;
	localparam int data_width = 32;
	localparam int addr_width = 16;
	localparam int byte_width = 8;
	localparam int lane_count = 8;
	localparam int checksum_count = 4;
	localparam int map_width = 3;
	localparam int param_bytes = 14;

	// printed offsets are register indices; byte address is four times the index
	localparam logic [11:0] idx_lane0_checksum = 12'h05a0;
	localparam logic [11:0] idx_lane1_checksum = 12'h05a1;
	localparam logic [11:0] idx_lane2_checksum = 12'h05a2;
	localparam logic [11:0] idx_lane3_checksum = 12'h05a3;
	localparam logic [11:0] idx_lane_force_powerdown = 12'h05b0;
	localparam logic [11:0] idx_lane_map_phys0_phys1 = 12'h05b2;

	localparam logic [7:0] rst_lane0_checksum = 8'hc3;
	localparam logic [7:0] rst_lane1_checksum = 8'hc4;
	localparam logic [7:0] rst_lane2_checksum = 8'hc5;
	localparam logic [7:0] rst_lane3_checksum = 8'hc6;
	localparam logic [7:0] rst_lane_force_powerdown = 8'h00;
	localparam logic [2:0] rst_phys0_map = 3'h0;
	localparam logic [2:0] rst_phys1_map = 3'h1;

	localparam int pos_phys0_map = 0;
	localparam int pos_phys1_map = 4;
endpackage

// ===== rtl/lane_checksum.sv
`timescale 1ns/1ps
module lane_checksum #(
	parameter int num_params = 14,
	parameter logic [7:0] reset_value = 8'h00
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [num_params*8-1:0] link_params,
	output logic [7:0] checksum
);
	logic [7:0] next_checksum;

	// modulo 256 falls out of the 8-bit accumulator wrapping
	always_comb begin
		next_checksum = 8'h00;
		for (int i = 0; i < num_params; i++) begin
			next_checksum = 8'(next_checksum + link_params[i*8 +: 8]);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			checksum <= reset_value;
		end else begin
			checksum <= next_checksum;
		end
	end
endmodule // lane_checksum

// ===== rtl/serial_lane_config_regs.sv
// Implementation choice: register access over APB.
`timescale 1ns/1ps
// Operation
// - lane 1 checksum is the lane 1 parameter sum modulo 256, read only
// - lane 2 checksum is the lane 2 parameter sum modulo 256, read only
// - lane 3 checksum is the lane 3 parameter sum modulo 256, read only
// - power-down bit 7 forces physical lane 7 down; resets to 0
// - bits 6, 5, 4 force physical lanes 6, 5, 4 down; reset 0
// - bits 3 and 2 force physical lanes 3 and 2 down when set
// - bits 1 and 0 force physical lanes 1 and 0 down when set
// - cleared bits keep lanes running; all eight bits read and write
// - map bits 6:4 choose logical lane for physical lane 1; reset 1
// - map bits 2:0 choose logical lane for physical lane 0; reset 0
// - lane 0 checksum is the lane 0 parameter sum modulo 256, read only
module serial_lane_config_regs #(
	parameter int num_params = lane_cfg_pkg::param_bytes
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [lane_cfg_pkg::addr_width-1:0] paddr,
	input wire logic [lane_cfg_pkg::data_width-1:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [lane_cfg_pkg::data_width-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [num_params*8-1:0] lane0_link_params,
	input wire logic [num_params*8-1:0] lane1_link_params,
	input wire logic [num_params*8-1:0] lane2_link_params,
	input wire logic [num_params*8-1:0] lane3_link_params,
	output logic [lane_cfg_pkg::lane_count-1:0] lane_powerdown,
	output logic [lane_cfg_pkg::map_width-1:0] phys0_logical_lane,
	output logic [lane_cfg_pkg::map_width-1:0] phys1_logical_lane
);
	localparam logic [7:0] checksum_reset [lane_cfg_pkg::checksum_count] = '{
		lane_cfg_pkg::rst_lane0_checksum, lane_cfg_pkg::rst_lane1_checksum,
		lane_cfg_pkg::rst_lane2_checksum, lane_cfg_pkg::rst_lane3_checksum};
	localparam logic [11:0] checksum_index [lane_cfg_pkg::checksum_count] = '{
		lane_cfg_pkg::idx_lane0_checksum, lane_cfg_pkg::idx_lane1_checksum,
		lane_cfg_pkg::idx_lane2_checksum, lane_cfg_pkg::idx_lane3_checksum};

	logic [num_params*8-1:0] params [lane_cfg_pkg::checksum_count];
	logic [7:0] checksum [lane_cfg_pkg::checksum_count];
	logic [lane_cfg_pkg::data_width-1:0] next_prdata;
	logic next_pready;
	logic next_pslverr;
	logic [lane_cfg_pkg::lane_count-1:0] next_lane_powerdown;
	logic [lane_cfg_pkg::map_width-1:0] next_phys0_logical_lane;
	logic [lane_cfg_pkg::map_width-1:0] next_phys1_logical_lane;
	logic setup_phase;
	logic write_commit;

	// byte address of a register index
	function automatic logic hits(input logic [lane_cfg_pkg::addr_width-1:0] addr,
		input logic [11:0] index);
		hits = addr == {2'b00, index, 2'b00};
	endfunction

	assign params[0] = lane0_link_params;
	assign params[1] = lane1_link_params;
	assign params[2] = lane2_link_params;
	assign params[3] = lane3_link_params;

	// checksums follow the parameters continuously, one cycle behind
	generate
		for (genvar g = 0; g < lane_cfg_pkg::checksum_count; g++) begin : gen_checksum
			lane_checksum #(
				.num_params(num_params),
				.reset_value(checksum_reset[g])
			) u_checksum (
				.pclk(pclk),
				.presetn(presetn),
				.link_params(params[g]),
				.checksum(checksum[g])
			);
		end
	endgenerate

	assign setup_phase = psel && !penable;
	// pready is high only in the access cycle, so a write lands exactly once
	assign write_commit = psel && penable && pready && pwrite && pstrb[0];

	always_comb begin
		next_pready = setup_phase;
		next_pslverr = 1'b0;
		next_prdata = '0;
		if (setup_phase) begin
			next_pslverr = 1'b1;
			for (int i = 0; i < lane_cfg_pkg::checksum_count; i++) begin
				if (hits(paddr, checksum_index[i])) begin
					next_pslverr = 1'b0;
					next_prdata = {24'h00_0000, checksum[i]};
				end
			end
			if (hits(paddr, lane_cfg_pkg::idx_lane_force_powerdown)) begin
				next_pslverr = 1'b0;
				next_prdata = {24'h00_0000, lane_powerdown};
			end
			if (hits(paddr, lane_cfg_pkg::idx_lane_map_phys0_phys1)) begin
				next_pslverr = 1'b0;
				next_prdata = '0;
				next_prdata[lane_cfg_pkg::pos_phys1_map +: 3] = phys1_logical_lane;
				next_prdata[lane_cfg_pkg::pos_phys0_map +: 3] = phys0_logical_lane;
			end
		end
	end

	// checksum indices are never written; reserved bits are simply not stored
	always_comb begin
		next_lane_powerdown = lane_powerdown;
		next_phys0_logical_lane = phys0_logical_lane;
		next_phys1_logical_lane = phys1_logical_lane;
		if (write_commit && hits(paddr, lane_cfg_pkg::idx_lane_force_powerdown)) begin
			next_lane_powerdown = pwdata[7:0];
		end
		if (write_commit && hits(paddr, lane_cfg_pkg::idx_lane_map_phys0_phys1)) begin
			next_phys1_logical_lane = pwdata[lane_cfg_pkg::pos_phys1_map +: 3];
			next_phys0_logical_lane = pwdata[lane_cfg_pkg::pos_phys0_map +: 3];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
			pready <= 1'b0;
			pslverr <= 1'b0;
			lane_powerdown <= lane_cfg_pkg::rst_lane_force_powerdown;
			phys0_logical_lane <= lane_cfg_pkg::rst_phys0_map;
			phys1_logical_lane <= lane_cfg_pkg::rst_phys1_map;
		end else begin
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
			lane_powerdown <= next_lane_powerdown;
			phys0_logical_lane <= next_phys0_logical_lane;
			phys1_logical_lane <= next_phys1_logical_lane;
		end
	end
endmodule // serial_lane_config_regs

// ===== testbench/lane_rx_model.sv
`timescale 1ns/1ps
module lane_rx_model (
	input logic [7:0] lane_powerdown,
	output logic [7:0] lane_active);
	assign lane_active = ~lane_powerdown;
endmodule // lane_rx_model

// ===== testbench/lane_cfg_asserts.sv
`timescale 1ns/1ps
module lane_cfg_asserts (
	input logic pclk,
	input logic presetn,
	input logic psel,
	input logic penable,
	input logic pwrite,
	input logic [15:0] paddr,
	input logic [31:0] pwdata,
	input logic [31:0] prdata,
	input logic pready,
	input logic [7:0] lane_powerdown,
	input logic [2:0] phys0_logical_lane,
	input logic [2:0] phys1_logical_lane);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire logic w = pready && pwrite;
	wire logic r = pready && !pwrite;
	wire logic pd = paddr == 16'h16c0;
	wire logic mp = paddr == 16'h16c8;
	wire logic [7:0] wb = pwdata[7:0];
	wire logic [7:0] map = {1'h0, phys1_logical_lane, 1'h0, phys0_logical_lane};
	a_ready_due: assert property (psel && !penable |=> pready) else $error("late");
	a_ready_once: assert property (pready |=> !pready) else $error("long");
	a_pd_set: assert property (w && pd |=> lane_powerdown == $past(wb)) else $error("pd");
	a_pd_keep: assert property (!(w && pd) |=> $stable(lane_powerdown)) else $error("pd");
	a_pd_rd: assert property (r && pd |-> prdata == 32'(lane_powerdown)) else $error("pd");
	a_map_set: assert property (w && mp |=> map == ($past(wb) & 8'h77)) else $error("map");
	a_map_keep: assert property (!(w && mp) |=> $stable(map)) else $error("map");
	a_map_rd: assert property (r && mp |-> prdata == 32'(map)) else $error("map");
endmodule // lane_cfg_asserts
bind serial_lane_config_regs lane_cfg_asserts lane_cfg_asserts_i (.*);

// ===== testbench/tb.sv
`timescale 1ns/1ps
module tb;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, e;
	logic [15:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, q;
	logic [3:0] pstrb = 4'hf;
	logic [7:0] lane_powerdown, lane_active;
	logic [2:0] phys0_logical_lane, phys1_logical_lane;
	logic [111:0] lane0_link_params = {14{8'h05}}, lane1_link_params = {14{8'h2a}};
	logic [111:0] lane2_link_params = {14{8'h4f}}, lane3_link_params = {14{8'h74}};
	int n_mismatch = 0, num_checks = 0;
	serial_lane_config_regs serial_lane_config_regs_i (.*);
	lane_rx_model lane_rx_model_i (.*);
	initial forever #50 pclk = ~pclk;
	task finish_test(input bit hung);
		n_mismatch += hung;
		$display("%0d checks %0d wrong", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] s, x);
		num_checks++;
		n_mismatch += int'(s !== x);
		if (s !== x) $display("wrong value at %0t: %h not %h", $time, s, x);
	endtask
	task automatic acc(input logic w, logic [15:0] a, logic [31:0] d);
		int k = 0;
		@(posedge pclk);
		{psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'h1 && ++k < 20);
		if (k == 20) finish_test(1);
		{e, q} = {pslverr, prdata};
		{psel, penable} <= 2'h0;
	endtask
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1;
		chk(32'({lane_powerdown, phys1_logical_lane, phys0_logical_lane}), 32'h0000_0008);
		for (int i = 0; i < 8; i++) begin
			acc(1, 16'h16c8, 32'(8'h88 | 8'(15 * i + 7)));
			acc(0, 16'h16c8, 0);
			chk(q, 32'(8'(15 * i + 7)));
			chk(32'(e), 32'h0000_0000);
			acc(1, 16'h16c0, 32'(1 << i));
			acc(0, 16'h16c0, 0);
			chk(q, 32'(1 << i));
			chk(32'({lane_powerdown, ~lane_active}), 32'(257 << i));
		end
		for (int i = 0; i < 4; i++) begin
			acc(1, 16'h1680 + 16'(4 * i), '1);
			acc(0, 16'h1680 + 16'(4 * i), 0);
			chk(q, 32'(8'(14 * (37 * i + 5))));
		end
		lane1_link_params <= {14{8'h01}};
		acc(0, 16'h1684, 0);
		chk(q, 32'h0000_000e);
		acc(0, 16'h1690, 0);
		chk({q[30:0], e}, 32'h0000_0001);
		$display("register tests done");
		finish_test(0);
	end
endmodule // tb
